// ---- logic/pars_pkg.sv ----
// Constants shared by the pixel array row and column sequencer.
// Assumes a single 25 MHz clock domain and a synchronous active-high reset.
package pars_pkg;

    // ------------------------------------------------------------------
    // Array geometry and word widths
    // ------------------------------------------------------------------
    localparam int ROWS        = 512;
    localparam int COLS        = 512;
    localparam int IDX_W       = 9;
    localparam int CODE_W      = 10;
    localparam int FIFO_DEPTH  = 32;

    // ------------------------------------------------------------------
    // Pin vector layout after the input synchroniser
    // ------------------------------------------------------------------
    localparam int PULSE_N      = 8;
    localparam int P_READ_ADV   = 0;
    localparam int P_RESET_ADV  = 1;
    localparam int P_READ_LOAD  = 2;
    localparam int P_RESET_LOAD = 3;
    localparam int P_ROW_START  = 4;
    localparam int P_COL_START  = 5;
    localparam int P_COL_LOAD   = 6;
    localparam int P_COL_ADV    = 7;
    localparam int PIN_W        = PULSE_N + 2 + 2 * IDX_W + 2 * CODE_W;

    // ------------------------------------------------------------------
    // Reset values and the saturation code
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0]  IDX_RESET   = 9'h000;
    localparam logic [CODE_W-1:0] CODE_RESET  = 10'h000;
    localparam logic [CODE_W-1:0] CODE_MAX    = 10'h3ff;

    // ------------------------------------------------------------------
    // Gain select codes, binary: 1, 2, 4 or 8
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PARS_GAIN_X1 = 2'h0,
        PARS_GAIN_X2 = 2'h1,
        PARS_GAIN_X4 = 2'h2,
        PARS_GAIN_X8 = 2'h3
    } pars_gain_t;

    // ------------------------------------------------------------------
    // Controller timing figures, for reference by the line timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS       = 40;
    localparam int ROW_BLANKING_NS     = 3200;
    localparam int PIXEL_PERIOD_NS     = 125;
    localparam int ROW_BLANKING_CYC    = (ROW_BLANKING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIXEL_PERIOD_CYC    = (PIXEL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : pars_pkg

// ---- logic/pars_stream_if.sv ----
// Valid/ready word stream used between the sequencer and its pixel FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface pars_stream_if #(parameter int WIDTH = 10);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input  ready);
    modport snk (input  valid, input  data, output ready);
endinterface : pars_stream_if

// ---- logic/pars_fifo.sv ----
// Flip-flop FIFO for converted pixel codes.
// Assumes one clock, a synchronous reset and a clock enable that freezes it.
`timescale 1ns/1ps
module pars_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    // Clock, reset and enable
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   ce,
    // Fill and drain sides
    pars_stream_if.snk  wr,
    pars_stream_if.src  rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW:0]      wp_reg;
    logic [AW:0]      wp_next;
    logic [AW:0]      rp_reg;
    logic [AW:0]      rp_next;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // Full when pointers match in index but differ in wrap bit.
    assign full     = (wp_reg[AW-1:0] == rp_reg[AW-1:0]) && (wp_reg[AW] != rp_reg[AW]);
    assign empty    = (wp_reg == rp_reg);
    assign wr.ready = ~full;
    assign rd.valid = ~empty;
    assign rd.data  = mem_reg[rp_reg[AW-1:0]];
    assign push     = wr.valid & ~full;
    assign pop      = rd.ready & ~empty;

    // Next pointers and storage.
    always_comb begin
        mem_next = mem_reg;
        wp_next  = wp_reg + (AW+1)'(push);
        rp_next  = rp_reg + (AW+1)'(pop);
        if (push) begin
            mem_next[wp_reg[AW-1:0]] = wr.data;
        end
    end

    // Storage holds no reset; only the pointers need a defined value.
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else if (ce) begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            mem_reg <= mem_next;
        end
    end
endmodule : pars_fifo

// ---- logic/pars_sequencer.sv ----
// Row and column addressing of a 512 by 512 pixel array with a 10-bit
// pixel converter and a FIFO on the pixel code output.
// Assumes an external timing controller drives the pointer, gain and level pins; those pins are
// asynchronous and pass a two-stage synchroniser here.
//
// Functional notes
// - Each row pointer is a one-hot 512-bit selector, one row at a time.
// - An advance pulse moves a row pointer one row further down.
// - A preset load pulse copies the row start register into the pointer.
// - Two independent pointers, read and reset; their spacing sets exposure.
// - Double sampling uses signal and reset level; read row is reset at once.
// - Reading a row destroys its charge; no accumulation across exposures.
// - Reset pointer selecting a row clears it and starts its new exposure.
// - Selected row codes leave serially, one pixel after another.
// - A column start register lets readout begin at a programmed column.
// - Two static gain select pins choose one of four gains.
// - Each pixel sample becomes a 10-bit code on the parallel output.
// - The selectable gains are 1, 2, 4 and 8.
`timescale 1ns/1ps
module pars_sequencer (
    // Clock, reset and enable
    input  wire logic                             CLK,
    input  wire logic                             RESET,
    input  wire logic                             CE,
    // Row pointer pins
    input  wire logic                             READ_ROW_ADVANCE,
    input  wire logic                             RESET_ROW_ADVANCE,
    input  wire logic                             READ_ROW_PRESET_LOAD,
    input  wire logic                             RESET_ROW_PRESET_LOAD,
    input  wire logic                             ROW_START_LOAD,
    input  wire logic [pars_pkg::IDX_W-1:0]       ROW_START_VALUE,
    // Column pointer pins
    input  wire logic                             COLUMN_START_LOAD,
    input  wire logic [pars_pkg::IDX_W-1:0]       COLUMN_START_VALUE,
    input  wire logic                             COLUMN_PRESET_LOAD,
    input  wire logic                             COLUMN_POINTER_ADVANCE,
    // Gain pins
    input  wire logic                             GAIN_SELECT_LSB,
    input  wire logic                             GAIN_SELECT_MSB,
    // Column amplifier levels of the selected pixel
    input  wire logic [pars_pkg::CODE_W-1:0]      SIGNAL_LEVEL,
    input  wire logic [pars_pkg::CODE_W-1:0]      RESET_LEVEL,
    // Row selects and status
    output logic      [pars_pkg::ROWS-1:0]        READ_ROW_SELECT,
    output logic      [pars_pkg::ROWS-1:0]        RESET_ROW_SELECT,
    output logic      [pars_pkg::IDX_W-1:0]       EXPOSURE_ROWS,
    output logic      [pars_pkg::IDX_W-1:0]       COLUMN_INDEX,
    output logic                                  ROW_READ_CLEAR,
    output logic                                  ROW_EXPOSURE_START,
    // Pixel code stream
    output logic      [pars_pkg::CODE_W-1:0]      PIXEL_CODE_BUS,
    output logic                                  PIXEL_CODE_VALID,
    input  wire logic                             PIXEL_CODE_READY,
    output logic                                  PIXEL_FIFO_READY,
    output logic                                  PIXEL_OVERRUN
);
    localparam int W = pars_pkg::IDX_W;
    localparam int C = pars_pkg::CODE_W;

    // ------------------------------------------------------------------
    // Input synchroniser and pulse edge detection
    // ------------------------------------------------------------------
    logic [pars_pkg::PIN_W-1:0]   pin_raw;
    logic [pars_pkg::PIN_W-1:0]   sync1_reg;
    logic [pars_pkg::PIN_W-1:0]   sync2_reg;
    logic [pars_pkg::PULSE_N-1:0] prev_reg;
    logic [pars_pkg::PULSE_N-1:0] rise;
    logic [1:0]                   gain_code;
    logic [W-1:0]                 row_start_pin;
    logic [W-1:0]                 col_start_pin;
    logic [C-1:0]                 sig_lvl;
    logic [C-1:0]                 rst_lvl;

    assign pin_raw = {RESET_LEVEL, SIGNAL_LEVEL, COLUMN_START_VALUE, ROW_START_VALUE,
                      GAIN_SELECT_MSB, GAIN_SELECT_LSB,
                      COLUMN_POINTER_ADVANCE, COLUMN_PRESET_LOAD, COLUMN_START_LOAD,
                      ROW_START_LOAD, RESET_ROW_PRESET_LOAD, READ_ROW_PRESET_LOAD,
                      RESET_ROW_ADVANCE, READ_ROW_ADVANCE};
    assign rise          = sync2_reg[pars_pkg::PULSE_N-1:0] & ~prev_reg;
    assign gain_code     = sync2_reg[pars_pkg::PULSE_N+1:pars_pkg::PULSE_N];
    assign row_start_pin = sync2_reg[pars_pkg::PULSE_N+2+:W];
    assign col_start_pin = sync2_reg[pars_pkg::PULSE_N+2+W+:W];
    assign sig_lvl       = sync2_reg[pars_pkg::PULSE_N+2+2*W+:C];
    assign rst_lvl       = sync2_reg[pars_pkg::PULSE_N+2+2*W+C+:C];

    // Two stages before any logic; the first stage feeds only the second.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
        end else if (CE) begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg[pars_pkg::PULSE_N-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Row and column pointers
    // ------------------------------------------------------------------
    logic [W-1:0] row_start_reg, row_start_next;
    logic [W-1:0] col_start_reg, col_start_next;
    logic [W-1:0] read_idx_reg, read_idx_next;
    logic [W-1:0] reset_idx_reg, reset_idx_next;
    logic [W-1:0] col_idx_reg, col_idx_next;
    logic [W-1:0] expo_reg, expo_next;
    logic         read_clr_reg, read_clr_next;
    logic         expo_start_reg, expo_start_next;
    logic [pars_pkg::ROWS-1:0] read_sel_reg, read_sel_next;
    logic [pars_pkg::ROWS-1:0] reset_sel_reg, reset_sel_next;

    // Next pointer positions; a preset load wins over an advance.
    always_comb begin
        row_start_next = row_start_reg;
        col_start_next = col_start_reg;
        read_idx_next  = read_idx_reg;
        reset_idx_next = reset_idx_reg;
        col_idx_next   = col_idx_reg;
        if (rise[pars_pkg::P_ROW_START]) begin
            row_start_next = row_start_pin;
        end
        if (rise[pars_pkg::P_COL_START]) begin
            col_start_next = col_start_pin;
        end
        if (rise[pars_pkg::P_READ_LOAD]) begin
            read_idx_next = row_start_reg;
        end else if (rise[pars_pkg::P_READ_ADV]) begin
            read_idx_next = read_idx_reg + W'(1);
        end
        if (rise[pars_pkg::P_RESET_LOAD]) begin
            reset_idx_next = row_start_reg;
        end else if (rise[pars_pkg::P_RESET_ADV]) begin
            reset_idx_next = reset_idx_reg + W'(1);
        end
        if (rise[pars_pkg::P_COL_LOAD]) begin
            col_idx_next = col_start_reg;
        end else if (rise[pars_pkg::P_COL_ADV]) begin
            col_idx_next = col_idx_reg + W'(1);
        end
        expo_next = reset_idx_next - read_idx_next;
        // moving the read row clears it.
        read_clr_next = rise[pars_pkg::P_READ_LOAD] | rise[pars_pkg::P_READ_ADV];
        // newly selected reset row starts exposure.
        expo_start_next = rise[pars_pkg::P_RESET_LOAD] | rise[pars_pkg::P_RESET_ADV];
    end

    // one-hot decode of both row pointers.
    genvar gi;
    generate
        for (gi = 0; gi < pars_pkg::ROWS; gi++) begin : g_row
            assign read_sel_next[gi]  = (read_idx_next == W'(gi));
            assign reset_sel_next[gi] = (reset_idx_next == W'(gi));
        end
    endgenerate

    // Pointer registers; both start on row zero.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            row_start_reg  <= pars_pkg::IDX_RESET;
            col_start_reg  <= pars_pkg::IDX_RESET;
            read_idx_reg   <= pars_pkg::IDX_RESET;
            reset_idx_reg  <= pars_pkg::IDX_RESET;
            col_idx_reg    <= pars_pkg::IDX_RESET;
            expo_reg       <= pars_pkg::IDX_RESET;
            read_clr_reg   <= 1'b0;
            expo_start_reg <= 1'b0;
            read_sel_reg   <= {{(pars_pkg::ROWS-1){1'b0}}, 1'b1};
            reset_sel_reg  <= {{(pars_pkg::ROWS-1){1'b0}}, 1'b1};
        end else if (CE) begin
            row_start_reg  <= row_start_next;
            col_start_reg  <= col_start_next;
            read_idx_reg   <= read_idx_next;
            reset_idx_reg  <= reset_idx_next;
            col_idx_reg    <= col_idx_next;
            expo_reg       <= expo_next;
            read_clr_reg   <= read_clr_next;
            expo_start_reg <= expo_start_next;
            read_sel_reg   <= read_sel_next;
            reset_sel_reg  <= reset_sel_next;
        end
    end

    // ------------------------------------------------------------------
    // Converter and gain stage
    // ------------------------------------------------------------------
    logic [C-1:0]   diff;
    logic [C+2:0]   scaled;
    logic [C-1:0]   code;
    logic           overrun_reg, overrun_next;
    pars_stream_if #(.WIDTH(C)) fill_if ();
    pars_stream_if #(.WIDTH(C)) drain_if ();

    // Double-sampled code: reset level minus signal level, clamped at zero.
    always_comb begin
        diff = (rst_lvl > sig_lvl) ? (rst_lvl - sig_lvl) : pars_pkg::CODE_RESET;
        case (pars_pkg::pars_gain_t'(gain_code))
            // gains of 1, 2, 4 and 8.
            pars_pkg::PARS_GAIN_X1: scaled = {3'h0, diff};
            pars_pkg::PARS_GAIN_X2: scaled = {2'h0, diff, 1'h0};
            pars_pkg::PARS_GAIN_X4: scaled = {1'h0, diff, 2'h0};
            pars_pkg::PARS_GAIN_X8: scaled = {diff, 3'h0};
            default:                scaled = {3'h0, diff};
        endcase
        code = (scaled[C+2:C] != 3'h0) ? pars_pkg::CODE_MAX : scaled[C-1:0];
    end

    // one code per column advance, in column order.
    assign fill_if.valid = rise[pars_pkg::P_COL_ADV];
    assign fill_if.data  = code;
    // The pins cannot be stalled, so a code that meets a full FIFO is lost
    // and flagged; the controller must slow its column clock instead.
    assign overrun_next  = overrun_reg | (fill_if.valid & ~fill_if.ready);

    pars_fifo #(
        .WIDTH (C),
        .DEPTH (pars_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk (CLK),
        .rst (RESET),
        .ce  (CE),
        .wr  (fill_if),
        .rd  (drain_if)
    );

    // ------------------------------------------------------------------
    // Registered output stage
    // ------------------------------------------------------------------
    logic         out_valid_reg, out_valid_next;
    logic [C-1:0] out_code_reg, out_code_next;
    logic         fifo_rdy_reg;

    assign drain_if.ready = ~out_valid_reg | PIXEL_CODE_READY;

    // Take a new word when the output stage is empty or being drained.
    always_comb begin
        out_valid_next = out_valid_reg;
        out_code_next  = out_code_reg;
        if (drain_if.ready) begin
            out_valid_next = drain_if.valid;
            if (drain_if.valid) begin
                out_code_next = drain_if.data;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            out_valid_reg <= 1'b0;
            out_code_reg  <= pars_pkg::CODE_RESET;
            fifo_rdy_reg  <= 1'b0;
            overrun_reg   <= 1'b0;
        end else if (CE) begin
            out_valid_reg <= out_valid_next;
            out_code_reg  <= out_code_next;
            fifo_rdy_reg  <= fill_if.ready;
            overrun_reg   <= overrun_next;
        end
    end

    assign READ_ROW_SELECT    = read_sel_reg;
    assign RESET_ROW_SELECT   = reset_sel_reg;
    assign EXPOSURE_ROWS      = expo_reg;
    assign COLUMN_INDEX       = col_idx_reg;
    assign ROW_READ_CLEAR     = read_clr_reg;
    assign ROW_EXPOSURE_START = expo_start_reg;
    assign PIXEL_CODE_BUS     = out_code_reg;
    assign PIXEL_CODE_VALID   = out_valid_reg;
    assign PIXEL_FIFO_READY   = fifo_rdy_reg;
    assign PIXEL_OVERRUN      = overrun_reg;
endmodule : pars_sequencer

// ---- test/pars_seq_asserts.sv ----
// Checker for the row and column sequencer, bound to its top ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module pars_seq_asserts (
    // Clock and pins
    input wire logic         CLK,
    input wire logic         RESET,
    input wire logic         CE,
    input wire logic         READ_ROW_ADVANCE,
    input wire logic         RESET_ROW_ADVANCE,
    // Observed outputs and the sink ready
    input wire logic [511:0] READ_ROW_SELECT,
    input wire logic [511:0] RESET_ROW_SELECT,
    input wire logic [8:0]   EXPOSURE_ROWS,
    input wire logic         ROW_READ_CLEAR,
    input wire logic         ROW_EXPOSURE_START,
    input wire logic [9:0]   PIXEL_CODE_BUS,
    input wire logic         PIXEL_CODE_VALID,
    input wire logic         PIXEL_CODE_READY
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    // Row number of a one-hot select; a plain scan keeps it obvious.
    function automatic logic [8:0] row_of(input logic [511:0] v);
        logic [8:0] r;
        r = 9'h000;
        for (int i = 0; i < 512; i++) begin
            if (v[i]) r = i[8:0];
        end
        return r;
    endfunction : row_of

    // A pointer move is flagged for exactly one cycle.
    sequence s_clear_pulse;
        ROW_READ_CLEAR ##1 !ROW_READ_CLEAR;
    endsequence
    sequence s_start_pulse;
        ROW_EXPOSURE_START ##1 !ROW_EXPOSURE_START;
    endsequence

    AST_READ_ONE_HOT: assert property ($onehot(READ_ROW_SELECT))
        else $error("read row select not one-hot");
    AST_RESET_ONE_HOT: assert property ($onehot(RESET_ROW_SELECT))
        else $error("reset row select not one-hot");
    AST_READ_STILL: assert property (!ROW_READ_CLEAR |-> $stable(READ_ROW_SELECT))
        else $error("read row moved without a clear pulse");
    AST_RESET_STILL: assert property (!ROW_EXPOSURE_START |-> $stable(RESET_ROW_SELECT))
        else $error("reset row moved without a start pulse");
    AST_CLEAR_SINGLE: assert property ($rose(ROW_READ_CLEAR) |-> s_clear_pulse)
        else $error("row clear pulse longer than one cycle");
    AST_READ_ADVANCE: assert property ($rose(READ_ROW_ADVANCE) && CE |-> ##[2:5] s_clear_pulse)
        else $error("read advance gave no row clear");
    AST_RESET_ADVANCE: assert property ($rose(RESET_ROW_ADVANCE) && CE |-> ##[2:5] s_start_pulse)
        else $error("reset advance gave no exposure start");
    AST_EXPOSURE_GAP: assert property ($stable(READ_ROW_SELECT) && $stable(RESET_ROW_SELECT)
        |-> EXPOSURE_ROWS == row_of(RESET_ROW_SELECT) - row_of(READ_ROW_SELECT))
        else $error("exposure rows differ from pointer spacing");
    AST_CODE_HOLD: assert property (PIXEL_CODE_VALID && !PIXEL_CODE_READY
        |=> PIXEL_CODE_VALID && $stable(PIXEL_CODE_BUS))
        else $error("pixel code dropped before it was taken");
endmodule : pars_seq_asserts

bind pars_sequencer pars_seq_asserts u_asserts (
    .CLK(CLK), .RESET(RESET), .CE(CE),
    .READ_ROW_ADVANCE(READ_ROW_ADVANCE), .RESET_ROW_ADVANCE(RESET_ROW_ADVANCE),
    .READ_ROW_SELECT(READ_ROW_SELECT), .RESET_ROW_SELECT(RESET_ROW_SELECT),
    .EXPOSURE_ROWS(EXPOSURE_ROWS), .ROW_READ_CLEAR(ROW_READ_CLEAR),
    .ROW_EXPOSURE_START(ROW_EXPOSURE_START), .PIXEL_CODE_BUS(PIXEL_CODE_BUS),
    .PIXEL_CODE_VALID(PIXEL_CODE_VALID), .PIXEL_CODE_READY(PIXEL_CODE_READY)
);

// ---- test/pars_ctrl_model.sv ----
// Timing controller model: drives the pointer, gain and level pins of the sequencer from tasks.
// Assumes one shared clock; pins change only at falling edges.
`timescale 1ns/1ps
module pars_ctrl_model (
    // Clock
    input wire logic   clk,
    // Pins towards the sequencer
    output logic [7:0] pins,
    output logic [8:0] row_val,
    output logic [8:0] col_val,
    output logic [1:0] gain,
    output logic [9:0] sig_lvl,
    output logic [9:0] rst_lvl
);
    // Mirrors of what the sequencer should hold after each pulse.
    logic [8:0] rd_idx;
    logic [8:0] rs_idx;
    logic [8:0] col_idx;
    logic [8:0] row_start;
    logic [8:0] col_start;

    // Back to the state the sequencer takes on reset.
    task automatic clear;
        pins = 8'h00;
        {row_val, col_val, rd_idx, rs_idx, col_idx, row_start, col_start} = '0;
        {gain, sig_lvl, rst_lvl} = '0;
    endtask : clear

    initial clear();

    task automatic pulse(input int idx);
        @(negedge clk);
        pins[idx] = 1'b1;
        case (idx)
            pars_pkg::P_READ_ADV:   rd_idx = rd_idx + 9'h001;
            pars_pkg::P_RESET_ADV:  rs_idx = rs_idx + 9'h001;
            pars_pkg::P_READ_LOAD:  rd_idx = row_start;
            pars_pkg::P_RESET_LOAD: rs_idx = row_start;
            pars_pkg::P_ROW_START:  row_start = row_val;
            pars_pkg::P_COL_START:  col_start = col_val;
            pars_pkg::P_COL_LOAD:   col_idx = col_start;
            default:                col_idx = col_idx + 9'h001;
        endcase
        // Three cycles high and low so the two-stage synchroniser never misses it.
        repeat (3) @(negedge clk);
        pins[idx] = 1'b0;
        repeat (3) @(negedge clk);
    endtask : pulse

    task automatic load_start(input int idx, input logic [8:0] v);
        if (idx == pars_pkg::P_ROW_START)
            row_val = v;
        else
            col_val = v;
        repeat (3) @(negedge clk);
        pulse(idx);
    endtask : load_start

    task automatic set_gain(input logic [1:0] g);
        gain = g;
        repeat (3) @(negedge clk);
    endtask : set_gain

    task automatic convert(input logic [9:0] s, input logic [9:0] r);
        sig_lvl = s;
        rst_lvl = r;
        repeat (3) @(negedge clk);
        pulse(pars_pkg::P_COL_ADV);
    endtask : convert
endmodule : pars_ctrl_model

// ---- test/testbench.sv ----
// Self-checking bench for the row and column sequencer.
// Assumes the controller model and the bound checker are compiled with it.
`timescale 1ns/1ps
module testbench;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         ce = 1'b1;
    logic         ready = 1'b0;
    logic [1:0]   rdy_mode = 2'h0;
    logic [7:0]   pins;
    logic [8:0]   row_val, col_val, expo, col_index;
    logic [1:0]   gain;
    logic [9:0]   sig_lvl, rst_lvl, code, s, r;
    logic [511:0] read_sel, reset_sel;
    logic         clear, start, valid, fifo_rdy, overrun;
    logic [9:0]   exp_q[$];
    int           seed, k, fails = 0, cmp_count = 0, cycles = 0;

    always #20 clk = ~clk;

    pars_ctrl_model u_ctrl (.clk(clk), .pins(pins), .row_val(row_val), .col_val(col_val),
        .gain(gain), .sig_lvl(sig_lvl), .rst_lvl(rst_lvl));

    pars_sequencer uut (
        .CLK(clk), .RESET(rst), .CE(ce),
        .READ_ROW_ADVANCE(pins[pars_pkg::P_READ_ADV]),
        .RESET_ROW_ADVANCE(pins[pars_pkg::P_RESET_ADV]),
        .READ_ROW_PRESET_LOAD(pins[pars_pkg::P_READ_LOAD]),
        .RESET_ROW_PRESET_LOAD(pins[pars_pkg::P_RESET_LOAD]),
        .ROW_START_LOAD(pins[pars_pkg::P_ROW_START]), .ROW_START_VALUE(row_val),
        .COLUMN_START_LOAD(pins[pars_pkg::P_COL_START]), .COLUMN_START_VALUE(col_val),
        .COLUMN_PRESET_LOAD(pins[pars_pkg::P_COL_LOAD]),
        .COLUMN_POINTER_ADVANCE(pins[pars_pkg::P_COL_ADV]),
        .GAIN_SELECT_LSB(gain[0]), .GAIN_SELECT_MSB(gain[1]),
        .SIGNAL_LEVEL(sig_lvl), .RESET_LEVEL(rst_lvl),
        .READ_ROW_SELECT(read_sel), .RESET_ROW_SELECT(reset_sel),
        .EXPOSURE_ROWS(expo), .COLUMN_INDEX(col_index),
        .ROW_READ_CLEAR(clear), .ROW_EXPOSURE_START(start),
        .PIXEL_CODE_BUS(code), .PIXEL_CODE_VALID(valid), .PIXEL_CODE_READY(ready),
        .PIXEL_FIFO_READY(fifo_rdy), .PIXEL_OVERRUN(overrun)
    );

    // Reset minus signal, clamped at zero, scaled by the gain, saturated.
    function automatic logic [9:0] exp_code(input logic [9:0] sv, rv, input logic [1:0] g);
        logic [20:0] d;
        d = (rv > sv) ? ({11'h000, rv - sv} << g) : 21'h000000;
        return (d > 21'h0003ff) ? 10'h3ff : d[9:0];
    endfunction : exp_code

    task automatic check(input logic [511:0] seen, input logic [511:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic rows;
        check(read_sel, 512'h1 << u_ctrl.rd_idx);
        check(reset_sel, 512'h1 << u_ctrl.rs_idx);
        check(expo, 9'(u_ctrl.rs_idx - u_ctrl.rd_idx));
    endtask : rows

    // The expected code is queued first, so a fast drain never finds the queue empty.
    task automatic pixel(input logic [9:0] sv, input logic [9:0] rv);
        if (exp_q.size() < pars_pkg::FIFO_DEPTH + 1)
            exp_q.push_back(exp_code(sv, rv, u_ctrl.gain));
        u_ctrl.convert(sv, rv);
    endtask : pixel

    task automatic drain;
        rdy_mode = 2'h1;
        for (int n = 0; n < 200 && exp_q.size() != 0; n++)
            @(negedge clk);
        repeat (2) @(negedge clk);
        check(exp_q.size(), 0);
        check(valid, 1'b0);
    endtask : drain

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // Sink side: ready low, high or stalling at random.
    always @(negedge clk) begin
        ready <= (rdy_mode == 2'h2) ? (($random(seed) & 3) != 0) : rdy_mode[0];
    end

    // Every code taken must be the next one expected, in column order.
    always @(posedge clk) begin
        cycles++;
        if (valid === 1'b1 && ready === 1'b1) begin
            if (exp_q.size() == 0)
                check(1'b1, 1'b0);
            else
                check(code, exp_q.pop_front());
        end
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        seed = 89699;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        rows();
        // Preset the last row, wrap past it, then sync back.
        u_ctrl.load_start(pars_pkg::P_ROW_START, 9'h1ff);
        u_ctrl.pulse(pars_pkg::P_READ_LOAD);
        rows();
        u_ctrl.pulse(pars_pkg::P_READ_ADV);
        rows();
        u_ctrl.pulse(pars_pkg::P_READ_LOAD);
        rows();
        for (int i = 0; i < 20; i++) begin
            k = {$random(seed)} % 5;
            if (k == 4)
                u_ctrl.load_start(pars_pkg::P_ROW_START, 9'($random(seed)));
            else
                u_ctrl.pulse(k);
            rows();
        end
        ce = 1'b0;
        repeat (5) @(negedge clk);
        ce = 1'b1;
        rows();
        // row blanking first, then windowed columns at every gain.
        repeat (pars_pkg::ROW_BLANKING_CYC) @(negedge clk);
        rdy_mode = 2'h2;
        u_ctrl.load_start(pars_pkg::P_COL_START, 9'h1e0);
        u_ctrl.pulse(pars_pkg::P_COL_LOAD);
        check(col_index, u_ctrl.col_idx);
        for (int g = 0; g < 4; g++) begin
            u_ctrl.set_gain(2'(g));
            for (int j = 0; j < 6; j++) begin
                s = (j == 0) ? 10'h3ff : 10'($random(seed));
                r = (j == 1) ? 10'h3ff : 10'($random(seed));
                pixel(s, r);
                check(col_index, u_ctrl.col_idx);
            end
        end
        drain();
        // Stall the sink until the buffer refuses, then empty it.
        rdy_mode = 2'h0;
        repeat (40) pixel(10'($random(seed)), 10'h3ff);
        check(fifo_rdy, 1'b0);
        check(overrun, 1'b1);
        drain();
        check(fifo_rdy, 1'b1);
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        u_ctrl.clear();
        rows();
        check(overrun, 1'b0);
        u_ctrl.pulse(pars_pkg::P_RESET_ADV);
        rows();
        conclude();
    end
endmodule : testbench
